// File: tbc_pkg.sv
// constants and types for the pwm time-base counter
package tbc_pkg;
  // register byte offsets
  localparam logic [7:0] TBC_OFF_CTRL   = 8'h00;
  localparam logic [7:0] TBC_OFF_COUNT  = 8'h04;
  localparam logic [7:0] TBC_OFF_PERIOD = 8'h08;
  localparam logic [7:0] TBC_OFF_SEVT   = 8'h0c;
  localparam logic [7:0] TBC_OFF_ISTAT  = 8'h10;
  localparam logic [7:0] TBC_OFF_IEN    = 8'h14;
  localparam logic [7:0] TBC_OFF_ICLR   = 8'h18;
  // field positions
  localparam int TBC_CTRL_EN_BIT   = 15;
  localparam int TBC_POST_LSB      = 4;
  localparam int TBC_PRESC_LSB     = 2;
  localparam int TBC_MODE_LSB      = 0;
  localparam int TBC_DIR_BIT       = 15;
  localparam int TBC_IRQ_TB_BIT    = 0;
  localparam int TBC_IRQ_SEVT_BIT  = 1;
  // widths and reset values
  localparam int TBC_CNT_W         = 15;
  localparam int TBC_IRQ_W         = 2;
  localparam logic [15:0] TBC_RST_WORD = 16'h0000;
  // prescale select codes and divisors minus one
  localparam logic [1:0] TBC_PRESC_1  = 2'b00;
  localparam logic [1:0] TBC_PRESC_4  = 2'b01;
  localparam logic [1:0] TBC_PRESC_16 = 2'b10;
  localparam logic [5:0] TBC_DIV1_M1  = 6'h00;
  localparam logic [5:0] TBC_DIV4_M1  = 6'h03;
  localparam logic [5:0] TBC_DIV16_M1 = 6'h0f;
  localparam logic [5:0] TBC_DIV64_M1 = 6'h3f;
  // counting modes
  typedef enum logic [1:0] {
    TBC_MODE_FREE   = 2'b00,
    TBC_MODE_SINGLE = 2'b01,
    TBC_MODE_UPDN   = 2'b10,
    TBC_MODE_UPDN2  = 2'b11
  } tbc_mode_t;
endpackage

// File: tbc_time_base.sv
// pwm time-base counter with ahb-lite register slave
// What this block does
// - four-bit postscale code n emits one time-base event per n+1 period events
// - prescale codes 11, 10, 01 give 64, 16, 4 cycles per count
// - mode field picks free-run, single event, up/down, up/down double update
// - count bit 15 is read-only direction flag, 1 counting down, reset 0
// - count bits 14..0 hold the count, read/write, reset zero
// - enable bit runs the time base when set, stops it when clear
// - a 15-bit period register sets the limit the count reaches
// - special trigger fires only when its direction matches the count direction
//
// Chosen here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ns
module tbc_time_base (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // time-base outputs to the pwm generators
  output logic      [14:0] count_value,
  output logic             count_direction_flag,
  output logic             tb_event,
  output logic             sevt_trigger,
  // interrupt
  output logic             irq
);
  import tbc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // register state
  logic        time_base_enable_reg, time_base_enable_next;
  logic [3:0]  output_postscale_sel_reg, output_postscale_sel_next;
  logic [1:0]  input_prescale_sel_reg, input_prescale_sel_next;
  tbc_mode_t   count_mode_sel_reg, count_mode_sel_next;
  logic [14:0] count_reg, count_next;
  logic        dir_reg, dir_next;
  logic [14:0] period_value_reg, period_value_next;
  logic        trigger_direction_sel_reg, trigger_direction_sel_next;
  logic [14:0] sevt_cmp_reg, sevt_cmp_next;
  logic [1:0]  istat_reg, istat_next;
  logic [1:0]  ien_reg, ien_next;
  logic [5:0]  presc_cnt_reg, presc_cnt_next;
  logic [3:0]  post_cnt_reg, post_cnt_next;
  logic        tb_event_reg, tb_event_next;
  logic        sevt_reg, sevt_next;
  logic        irq_reg, irq_next;
  // bus state
  logic        wr_pend_reg, wr_pend_next;
  logic [7:0]  wr_addr_reg, wr_addr_next;
  logic [31:0] hrdata_reg, hrdata_next;
  // combinational helpers
  logic        addr_ok;
  logic        tick;
  logic        period_evt;
  logic [5:0]  div_m1;
  logic [7:0]  a_off;
  logic        cnt_wr;
  logic        ctrl_wr;

  ////////////////////////////////////////////////////////////////////////
  // prescaler terminal count per select code
  always_comb begin
    case (input_prescale_sel_reg)
      TBC_PRESC_1:  div_m1 = TBC_DIV1_M1;
      TBC_PRESC_4:  div_m1 = TBC_DIV4_M1;
      TBC_PRESC_16: div_m1 = TBC_DIV16_M1;
      default:      div_m1 = TBC_DIV64_M1;
    endcase
  end

  // bus decode; the slave never stalls, so hready is always its own
  assign addr_ok = hsel && hready && htrans[1];
  assign a_off   = {haddr[7:2], 2'b00};
  assign cnt_wr  = wr_pend_reg && (wr_addr_reg == TBC_OFF_COUNT);
  assign ctrl_wr = wr_pend_reg && (wr_addr_reg == TBC_OFF_CTRL);
  // greater-or-equal: a smaller prescale chosen while running ticks at once
  // instead of letting the prescale counter run on to its wrap
  assign tick    = time_base_enable_reg && presc_cnt_reg >= div_m1;

  ////////////////////////////////////////////////////////////////////////
  // next-state logic for counter, registers and bus
  always_comb begin
    time_base_enable_next      = time_base_enable_reg;
    output_postscale_sel_next  = output_postscale_sel_reg;
    input_prescale_sel_next    = input_prescale_sel_reg;
    count_mode_sel_next        = count_mode_sel_reg;
    count_next                 = count_reg;
    dir_next                   = dir_reg;
    period_value_next          = period_value_reg;
    trigger_direction_sel_next = trigger_direction_sel_reg;
    sevt_cmp_next              = sevt_cmp_reg;
    ien_next                   = ien_reg;
    presc_cnt_next             = presc_cnt_reg;
    post_cnt_next              = post_cnt_reg;
    period_evt                 = 1'b0;
    // prescaler only runs while enabled
    if (!time_base_enable_reg || tick) begin
      presc_cnt_next = 6'h00;
    end else begin
      presc_cnt_next = presc_cnt_reg + 6'h01;
    end
    // count step on each prescaled tick
    if (tick) begin
      if (!dir_reg) begin
        if (count_reg >= period_value_reg) begin
          case (count_mode_sel_reg)
            TBC_MODE_UPDN, TBC_MODE_UPDN2: begin
              dir_next   = 1'b1;
              count_next = (count_reg == 15'h0000) ? 15'h0000
                         : count_reg - 15'h0001;
              period_evt = (count_mode_sel_reg == TBC_MODE_UPDN2);
            end
            TBC_MODE_SINGLE: begin
              count_next            = 15'h0000;
              time_base_enable_next = 1'b0;
              period_evt            = 1'b1;
            end
            default: begin
              count_next = 15'h0000;
              period_evt = 1'b1;
            end
          endcase
        end else begin
          count_next = count_reg + 15'h0001;
        end
      end else if (count_reg == 15'h0000) begin
        dir_next   = 1'b0;
        count_next = (period_value_reg == 15'h0000) ? 15'h0000 : 15'h0001;
        period_evt = 1'b1;
      end else begin
        count_next = count_reg - 15'h0001;
      end
    end
    // only the up/down modes may count down
    if (!count_mode_sel_reg[1]) begin
      dir_next = 1'b0;
    end
    // postscaler: code n gives one event per n+1 period events
    tb_event_next = 1'b0;
    if (period_evt) begin
      if (post_cnt_reg == output_postscale_sel_reg) begin
        post_cnt_next = 4'h0;
        tb_event_next = 1'b1;
      end else begin
        post_cnt_next = post_cnt_reg + 4'h1;
      end
    end
    // special trigger compares value and direction on a tick
    sevt_next = tick && (count_reg == sevt_cmp_reg)
              && (dir_reg == trigger_direction_sel_reg);
    // data-phase writes; software beats the counter on the same edge
    if (wr_pend_reg) begin
      case (wr_addr_reg)
        TBC_OFF_CTRL: begin
          time_base_enable_next     = hwdata[TBC_CTRL_EN_BIT];
          output_postscale_sel_next = hwdata[TBC_POST_LSB +: 4];
          input_prescale_sel_next   = hwdata[TBC_PRESC_LSB +: 2];
          count_mode_sel_next       = tbc_mode_t'(hwdata[TBC_MODE_LSB +: 2]);
        end
        TBC_OFF_COUNT:  count_next = hwdata[TBC_CNT_W-1:0];
        TBC_OFF_PERIOD: period_value_next = hwdata[TBC_CNT_W-1:0];
        TBC_OFF_SEVT: begin
          trigger_direction_sel_next = hwdata[TBC_DIR_BIT];
          sevt_cmp_next              = hwdata[TBC_CNT_W-1:0];
        end
        TBC_OFF_IEN: ien_next = hwdata[TBC_IRQ_W-1:0];
        default: ;
      endcase
    end
    // sticky status: a new event wins over a clear in the same cycle
    istat_next = istat_reg;
    if (wr_pend_reg && (wr_addr_reg == TBC_OFF_ICLR)) begin
      istat_next = istat_reg & ~hwdata[TBC_IRQ_W-1:0];
    end
    istat_next[TBC_IRQ_TB_BIT]   = istat_next[TBC_IRQ_TB_BIT] | tb_event_next;
    istat_next[TBC_IRQ_SEVT_BIT] = istat_next[TBC_IRQ_SEVT_BIT] | sevt_next;
    irq_next = |(istat_next & ien_next);
    // address phase: latch writes, fetch read data for the data phase
    wr_pend_next = addr_ok && hwrite;
    wr_addr_next = a_off;
    hrdata_next  = 32'h0000_0000;
    if (addr_ok && !hwrite) begin
      case (a_off)
        TBC_OFF_CTRL: hrdata_next = {16'h0000, time_base_enable_reg, 7'h00,
          output_postscale_sel_reg, input_prescale_sel_reg,
          count_mode_sel_reg};
        TBC_OFF_COUNT:  hrdata_next = {16'h0000, dir_reg, count_reg};
        TBC_OFF_PERIOD: hrdata_next = {17'h00000, period_value_reg};
        TBC_OFF_SEVT:   hrdata_next = {16'h0000, trigger_direction_sel_reg,
                                       sevt_cmp_reg};
        TBC_OFF_ISTAT:  hrdata_next = {30'h00000000, istat_reg};
        TBC_OFF_IEN:    hrdata_next = {30'h00000000, ien_reg};
        default:        hrdata_next = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      time_base_enable_reg      <= 1'b0;
      output_postscale_sel_reg  <= 4'h0;
      input_prescale_sel_reg    <= 2'b00;
      count_mode_sel_reg        <= TBC_MODE_FREE;
      count_reg                 <= TBC_RST_WORD[14:0];
      dir_reg                   <= TBC_RST_WORD[15];
      period_value_reg          <= TBC_RST_WORD[14:0];
      trigger_direction_sel_reg <= 1'b0;
      sevt_cmp_reg              <= TBC_RST_WORD[14:0];
      istat_reg                 <= 2'b00;
      ien_reg                   <= 2'b00;
      presc_cnt_reg             <= 6'h00;
      post_cnt_reg              <= 4'h0;
      tb_event_reg              <= 1'b0;
      sevt_reg                  <= 1'b0;
      irq_reg                   <= 1'b0;
      wr_pend_reg               <= 1'b0;
      wr_addr_reg               <= 8'h00;
      hrdata_reg                <= 32'h0000_0000;
    end else begin
      time_base_enable_reg      <= time_base_enable_next;
      output_postscale_sel_reg  <= output_postscale_sel_next;
      input_prescale_sel_reg    <= input_prescale_sel_next;
      count_mode_sel_reg        <= count_mode_sel_next;
      count_reg                 <= count_next;
      dir_reg                   <= dir_next;
      period_value_reg          <= period_value_next;
      trigger_direction_sel_reg <= trigger_direction_sel_next;
      sevt_cmp_reg              <= sevt_cmp_next;
      istat_reg                 <= istat_next;
      ien_reg                   <= ien_next;
      presc_cnt_reg             <= presc_cnt_next;
      post_cnt_reg              <= post_cnt_next;
      tb_event_reg              <= tb_event_next;
      sevt_reg                  <= sevt_next;
      irq_reg                   <= irq_next;
      wr_pend_reg               <= wr_pend_next;
      wr_addr_reg               <= wr_addr_next;
      hrdata_reg                <= hrdata_next;
    end
  end

  // outputs straight from flops; zero-wait, always okay
  assign hrdata               = hrdata_reg;
  assign hreadyout            = 1'b1;
  assign hresp                = 1'b0;
  assign count_value          = count_reg;
  assign count_direction_flag = dir_reg;
  assign tb_event             = tb_event_reg;
  assign sevt_trigger         = sevt_reg;
  assign irq                  = irq_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_post_ratio: assert property (
    tb_event_reg |-> $past(period_evt)
      && ($past(post_cnt_reg) == $past(output_postscale_sel_reg)))
    else $error("time-base event not at postscale terminal count");
  chk_presc_gap: assert property (
    (tick && input_prescale_sel_reg == TBC_PRESC_4) |=>
      (!tick || input_prescale_sel_reg != TBC_PRESC_4)[*3])
    else $error("prescale 1:4 ticked too soon");
  chk_presc_one: assert property (
    (time_base_enable_reg && input_prescale_sel_reg == TBC_PRESC_1) |-> tick)
    else $error("prescale 1:1 missed a cycle");
  chk_free_wrap: assert property (
    (tick && !cnt_wr && count_mode_sel_reg == TBC_MODE_FREE
      && count_reg >= period_value_reg) |=> count_reg == 15'h0000)
    else $error("free-run count did not wrap at period");
  chk_single_stop: assert property (
    (tick && !ctrl_wr && !dir_reg && count_mode_sel_reg == TBC_MODE_SINGLE
      && count_reg >= period_value_reg) |=> !time_base_enable_reg)
    else $error("single event mode did not stop");
  chk_dir_turn: assert property (
    (tick && !ctrl_wr && !dir_reg && count_mode_sel_reg[1]
      && count_reg >= period_value_reg) |=> count_direction_flag)
    else $error("direction flag not set at top of up/down count");
  chk_dir_up_only: assert property (
    !count_mode_sel_reg[1] |=> !count_direction_flag)
    else $error("direction flag set outside up/down modes");
  chk_count_write: assert property (
    cnt_wr |=> count_value == $past(hwdata[14:0]))
    else $error("count write not taken");
  chk_stop_hold: assert property (
    (!time_base_enable_reg && !cnt_wr) |=> $stable(count_value))
    else $error("count moved while time base off");
  chk_trig_dir: assert property (
    sevt_trigger |-> $past(dir_reg) == $past(trigger_direction_sel_reg)
      && $past(count_reg) == $past(sevt_cmp_reg))
    else $error("special trigger on wrong direction or value");

  cov_tb_event: cover property (tb_event_reg);
  cov_sevt:     cover property (sevt_reg && dir_reg);
  cov_dir_fall: cover property ($fell(dir_reg));
  cov_irq:      cover property ($rose(irq_reg));

endmodule // tbc_time_base

// File: testbench.sv
// self-checking testbench for the pwm time-base counter
`timescale 1ns/1ns
module testbench;
  import tbc_pkg::*;
  typedef struct {
    logic [1:0]  mode;
    logic [1:0]  presc;
    logic [3:0]  post;
    logic [14:0] per;
    int          gap;
  } tbc_row_t;

  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [14:0] count_value;
  logic        count_direction_flag;
  logic        tb_event;
  logic        sevt_trigger;
  logic        irq;
  logic        mon_on;
  logic [14:0] prev_cnt;
  logic [31:0] v1;
  logic [31:0] v2;
  int          n_mismatch;
  int          cmp_count;
  int          c;
  // mode, prescale, postscale, period, cycles between two time-base events
  tbc_row_t rows [7] = '{'{2'h0, 2'h0, 4'h0, 15'h2, 3},
                         '{2'h0, 2'h1, 4'h1, 15'h1, 16},
                         '{2'h0, 2'h2, 4'h0, 15'h3, 64},
                         '{2'h0, 2'h3, 4'h0, 15'h0, 64},
                         '{2'h0, 2'h0, 4'hf, 15'h1, 32},
                         '{2'h2, 2'h0, 4'h0, 15'h2, 4},
                         '{2'h3, 2'h0, 4'h0, 15'h2, 2}};

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  // hready is looped back: the slave is the only one on the bus
  tbc_time_base u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .count_value(count_value),
    .count_direction_flag(count_direction_flag), .tb_event(tb_event),
    .sevt_trigger(sevt_trigger), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tmo;
    n_mismatch++;
    $display("wrong value wait expected done seen timeout");
    finish_test();
  endtask

  // one single ahb-lite transfer; the slave never stalls, but hready is polled
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) tmo();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) tmo();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(nm, e, x);
  endtask

  // waits for a pulse of tb_event (0) or sevt_trigger (1), counting edges
  task automatic wait_ev(input logic which, output int n);
    n = 0;
    do begin @(posedge hclk); n++; end
    while ((which ? sevt_trigger : tb_event) !== 1'b1 && n < 5000);
    if (n >= 5000) tmo();
  endtask

  function automatic logic [31:0] ctrl(input logic en, input logic [3:0] p,
                                       input logic [1:0] s,
                                       input logic [1:0] m);
    return {16'h0, en, 7'h0, p, s, m};
  endfunction

  // stop, clear the count, load the period, then start in the new setting
  task automatic cfg(input logic [1:0] m, input logic [1:0] s,
                     input logic [3:0] p, input logic [14:0] per);
    wr(TBC_OFF_CTRL, ctrl(1'b0, p, s, m));
    wr(TBC_OFF_COUNT, 32'h0);
    wr(TBC_OFF_PERIOD, {17'h0, per});
    wr(TBC_OFF_CTRL, ctrl(1'b1, p, s, m));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // in up/down modes a falling count must show the down flag, a rising one not
  always @(posedge hclk) begin
    if (mon_on && count_value !== prev_cnt)
      chk("direction", {31'h0, count_value < prev_cnt},
          {31'h0, count_direction_flag});
    prev_cnt <= count_value;
  end

  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
    hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; mon_on = 1'b0;
    prev_cnt = 15'h0; n_mismatch = 0; cmp_count = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    // the first gap after a change may be short, so measure the second
    for (int i = 0; i < 7; i++) begin
      mon_on <= 1'b0;
      cfg(rows[i].mode, rows[i].presc, rows[i].post, rows[i].per);
      mon_on <= rows[i].mode[1];
      wait_ev(1'b0, c);
      wait_ev(1'b0, c);
      chk("gap", rows[i].gap, c);
    end
    mon_on <= 1'b0;
    // special trigger on the up and then the down pass through compare 1
    for (int d = 0; d < 2; d++) begin
      wr(TBC_OFF_SEVT, {16'h0, d[0], 15'h1});
      cfg(2'h2, 2'h0, 4'h0, 15'h3);
      wait_ev(1'b1, c);
      chk("sevt count", d ? 32'h0 : 32'h2, {17'h0, count_value});
      chk("sevt dir", d, {31'h0, count_direction_flag});
    end
    // the direction bit is read-only, the count bits take the write
    wr(TBC_OFF_CTRL, 32'h0);
    wr(TBC_OFF_COUNT, 32'h8005);
    rd_chk("count reg", TBC_OFF_COUNT, 32'h5);
    chk("count out", 32'h5, {17'h0, count_value});
    wr(TBC_OFF_PERIOD, 32'h100);
    wr(TBC_OFF_CTRL, ctrl(1'b1, 4'h0, 2'h0, 2'h0));
    repeat (10) @(posedge hclk);
    wr(TBC_OFF_CTRL, 32'h0);
    bus(1'b0, TBC_OFF_COUNT, 32'h0, v1);
    repeat (10) @(posedge hclk);
    bus(1'b0, TBC_OFF_COUNT, 32'h0, v2);
    chk("ran", 32'h1, {31'h0, v1 > 32'h5});
    chk("held", v1, v2);
    // single event stops itself at the period and drops the enable
    cfg(2'h1, 2'h0, 4'h0, 15'h2);
    wait_ev(1'b0, c);
    repeat (3) @(posedge hclk);
    rd_chk("one ctrl", TBC_OFF_CTRL, ctrl(1'b0, 4'h0, 2'h0, 2'h1));
    chk("single count", 32'h0, {17'h0, count_value});
    // both event kinds have fired by now and nothing has cleared them
    rd_chk("istat both", TBC_OFF_ISTAT, 32'h3);
    chk("hresp", 32'h0, {31'h0, hresp});
    // interrupt: raise, mask, unmask, clear
    wr(TBC_OFF_ICLR, 32'h3);
    wr(TBC_OFF_IEN, 32'h1);
    rd_chk("istat clear", TBC_OFF_ISTAT, 32'h0);
    chk("irq idle", 32'h0, {31'h0, irq});
    cfg(2'h0, 2'h0, 4'h0, 15'h0);
    wait_ev(1'b0, c);
    wr(TBC_OFF_CTRL, 32'h0);
    repeat (2) @(posedge hclk);
    chk("irq set", 32'h1, {31'h0, irq});
    rd_chk("istat set", TBC_OFF_ISTAT, 32'h1);
    wr(TBC_OFF_IEN, 32'h0);
    repeat (2) @(posedge hclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(TBC_OFF_IEN, 32'h1);
    repeat (2) @(posedge hclk);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(TBC_OFF_ICLR, 32'h1);
    repeat (2) @(posedge hclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rd_chk("istat cleared", TBC_OFF_ISTAT, 32'h0);
    rd_chk("iclr reads", TBC_OFF_ICLR, 32'h0);
    rd_chk("unmapped", 8'h1c, 32'h0);
    // reset in mid-run while counting with the interrupt enabled
    cfg(2'h0, 2'h0, 4'h0, 15'h10);
    repeat (5) @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("reset outs", 32'h1, {12'h0, count_value, count_direction_flag,
        tb_event, sevt_trigger, irq, hreadyout});
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk("reset ctrl", TBC_OFF_CTRL, 32'h0);
    rd_chk("reset count", TBC_OFF_COUNT, 32'h0);
    rd_chk("reset period", TBC_OFF_PERIOD, 32'h0);
    rd_chk("reset ien", TBC_OFF_IEN, 32'h0);
    chk("idle count", 32'h0, {17'h0, count_value});
    finish_test();
  end
endmodule // testbench
